// ### include/burst_sram_defines.vh
`ifndef BURST_SRAM_DEFINES_VH
`define BURST_SRAM_DEFINES_VH

// Word and lane layout
`define LANE_COUNT 4
`define LANE_WIDTH 9
`define WORD_WIDTH 36
`define DATA_BITS_PER_LANE 8
// Default address width and burst counter width
`define ADDR_WIDTH_DEFAULT 21
`define BURST_BITS 2
// Burst order strap levels
`define ORDER_LINEAR 1'b0
`define ORDER_INTERLEAVED 1'b1
// Operation state codes
`define OP_IDLE 2'h0
`define OP_READ 2'h1
`define OP_WRITE 2'h2

`endif

// ### rtl/burst_counter.v
`timescale 1ns/1ps
`include "burst_sram_defines.vh"

module burst_counter (
  input wire clock, // System clock
  input wire reset, // Synchronous reset, active high
  input wire load, // Take new start bits
  input wire step, // Advance one beat
  input wire orderInterleaved, // 1 = interleaved, 0 = linear
  input wire [1:0] startBits, // Low two address bits
  output wire [1:0] lowAddr // Current low address
);
  reg [1:0] start_reg;
  reg [1:0] beat_reg;
  wire [1:0] beat_next;

  // Wraps after four beats, as a two-bit burst should
  assign beat_next = beat_reg + 2'h1;
  // Interleaved order XORs the beat count into the start bits
  assign lowAddr = orderInterleaved ? (start_reg ^ beat_reg)
                                    : (start_reg + beat_reg);

  always @(posedge clock) begin
    if (reset) begin
      start_reg <= 2'h0;
      beat_reg <= 2'h0;
    end else if (load) begin
      start_reg <= startBits;
      beat_reg <= 2'h0;
    end else if (step) begin
      beat_reg <= beat_next;
    end
  end
endmodule // burst_counter

// ### rtl/sync_burst_sram_control_port.v
`timescale 1ns/1ps
`include "burst_sram_defines.vh"

// Summary of operation
// - Capture address on qualified load edges while selected
// - Low two address bits load burst counter
// - Active-low byte strobes, write needs write-enable
// - Write-enable sampled only on qualified edges
// - Advance high steps the burst counter
// - Advance low loads a new address
// - Act only when clock-qualify is low
// - Selected when A low, B high, C low
// - Output enable low drives data pins
// - Output enable high tristates data pins
// - Data outputs off during write data phase
// - Outputs off first cycle after deselect
// - Outputs off while deselected
// - Clock-qualify high holds state, stays selected
// - Read data from previous captured address
// - Strap low linear, high interleaved order
// - Parity lines gated by their lane strobe
module sync_burst_sram_control_port #(
  parameter ADDR_WIDTH = `ADDR_WIDTH_DEFAULT, // Word address width
  parameter DEPTH = 64 // Words modelled in the array
) (
  input wire clock, // Memory clock
  input wire reset, // Synchronous reset, active high
  input wire [ADDR_WIDTH-1:0] address, // Address pins
  input wire advance_or_load, // 1 = advance burst, 0 = load
  input wire writeEnableN, // Write enable, active low
  input wire byte_lane_strobe_first_n, // Lane 0 strobe
  input wire byte_lane_strobe_second_n, // Lane 1 strobe
  input wire byte_lane_strobe_third_n, // Lane 2 strobe
  input wire byte_lane_strobe_fourth_n, // Lane 3 strobe
  input wire clock_qualify_n, // Clock qualify, active low
  input wire chip_select_a_n, // Chip select A, active low
  input wire chip_select_b, // Chip select B, active high
  input wire chip_select_c_n, // Chip select C, active low
  input wire outputEnableN, // Asynchronous output enable
  input wire burstOrderStrap, // 0 = linear, 1 = interleaved
  input wire [31:0] dataIn, // Data pins, input side
  input wire [3:0] parity_data_lines_in, // Parity pins, input
  output reg [31:0] dataOut, // Data pins, output side
  output reg [3:0] parity_data_lines_out, // Parity pins, output
  output wire dataOeN, // Low while driving data pins
  output wire selected // Device currently selected
);
  localparam OP_IDLE = `OP_IDLE;
  localparam OP_READ = `OP_READ;
  localparam OP_WRITE = `OP_WRITE;

  // Pins from the controller are on this clock; no synchroniser needed
  reg [ADDR_WIDTH-1:0] addr_reg;
  reg [1:0] op_reg;
  reg [3:0] strobe_reg;
  reg wasDeselected_reg;
  reg firstAfterDeselect_reg;
  reg orderStrap_reg;
  reg strapMeta_reg;
  reg [`WORD_WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_WIDTH-1:0] addr_next;
  reg [1:0] op_next;
  reg [3:0] strobe_next;
  reg wasDeselected_next;
  reg firstAfterDeselect_next;

  wire qualified;
  wire selectNow;
  wire [3:0] strobeNow;
  wire [1:0] lowAddr;
  wire [ADDR_WIDTH-1:0] effAddr;
  wire [`WORD_WIDTH-1:0] writeWord;
  wire [`WORD_WIDTH-1:0] readWord;
  wire loadNew;
  wire stepBurst;
  wire outputsMasked;
  wire writeNow;
  wire maskWrite;
  wire maskIdle;
  wire maskEmerge;

  assign qualified = ~clock_qualify_n;
  assign selectNow = ~chip_select_a_n & chip_select_b
                     & ~chip_select_c_n;
  assign strobeNow = ~{byte_lane_strobe_fourth_n, byte_lane_strobe_third_n,
                       byte_lane_strobe_second_n,
                       byte_lane_strobe_first_n};
  assign loadNew = qualified & ~advance_or_load & selectNow;
  // Advance only continues an access already running
  assign stepBurst = qualified & advance_or_load
                     & (op_reg != OP_IDLE);
  assign selected = (op_reg != OP_IDLE);

  burst_counter burst_counter_inst (
    .clock(clock),
    .reset(reset),
    .load(loadNew),
    .step(stepBurst),
    .orderInterleaved(orderStrap_reg),
    .startBits(address[1:0]),
    .lowAddr(lowAddr)
  );

  assign effAddr = {addr_reg[ADDR_WIDTH-1:2], lowAddr};

  // Address captured on the previous qualified rise; flow-through read
  assign readWord = mem[effAddr % DEPTH];

  // Strap is a board pin, not on this clock: two flops before use
  // Reset value matches an open strap, which means interleaved
  always @(posedge clock) begin
    if (reset) begin
      strapMeta_reg <= `ORDER_INTERLEAVED;
      orderStrap_reg <= `ORDER_INTERLEAVED;
    end else begin
      strapMeta_reg <= burstOrderStrap;
      orderStrap_reg <= strapMeta_reg;
    end
  end

  // Next state; clock-qualify high keeps every register as it is
  always @* begin
    addr_next = addr_reg;
    op_next = op_reg;
    strobe_next = strobe_reg;
    wasDeselected_next = wasDeselected_reg;
    firstAfterDeselect_next = firstAfterDeselect_reg;
    if (qualified) begin
      firstAfterDeselect_next = 1'b0;
      if (loadNew) begin
        addr_next = address;
        // High write-enable on the command cycle means a read
        op_next = writeEnableN ? OP_READ : OP_WRITE;
        firstAfterDeselect_next = wasDeselected_reg;
        wasDeselected_next = 1'b0;
      end else if (~advance_or_load) begin
        op_next = OP_IDLE;
        wasDeselected_next = 1'b1;
      end
      // Strobes apply per beat, including burst beats
      if (~writeEnableN | (stepBurst & (op_reg == OP_WRITE)))
        strobe_next = strobeNow;
      else
        strobe_next = 4'h0;
    end
  end

  // First access after reset counts as leaving the deselected state
  always @(posedge clock) begin
    if (reset) begin
      addr_reg <= {ADDR_WIDTH{1'b0}};
      op_reg <= OP_IDLE;
      strobe_reg <= 4'h0;
      wasDeselected_reg <= 1'b1;
      firstAfterDeselect_reg <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      op_reg <= op_next;
      strobe_reg <= strobe_next;
      wasDeselected_reg <= wasDeselected_next;
      firstAfterDeselect_reg <= firstAfterDeselect_next;
    end
  end

  // Write data arrives in the cycle after the command
  genvar lane;
  generate
    for (lane = 0; lane < `LANE_COUNT; lane = lane + 1) begin : g_lane
      assign writeWord[lane*`LANE_WIDTH +: `LANE_WIDTH] =
        strobe_reg[lane]
          ? {parity_data_lines_in[lane], dataIn[lane*8 +: 8]}
          : readWord[lane*`LANE_WIDTH +: `LANE_WIDTH];
    end
  endgenerate

  // Write lands on the data-phase edge; all strobes high stores nothing
  assign writeNow = qualified & (op_reg == OP_WRITE) & (|strobe_reg);

  always @(posedge clock) begin
    if (~reset & writeNow)
      mem[effAddr % DEPTH] <= writeWord;
  end

  integer i;
  always @* begin
    dataOut = 32'h0;
    parity_data_lines_out = 4'h0;
    for (i = 0; i < `LANE_COUNT; i = i + 1) begin
      dataOut[i*8 +: 8] = readWord[i*`LANE_WIDTH +: 8];
      parity_data_lines_out[i] = readWord[i*`LANE_WIDTH + 8];
    end
  end

  // Any mask overrides the asynchronous enable, avoiding bus contention
  assign maskWrite = (op_reg == OP_WRITE);
  assign maskIdle = (op_reg != OP_READ) & ~maskWrite;
  assign maskEmerge = firstAfterDeselect_reg;
  assign outputsMasked = maskWrite | maskIdle | maskEmerge;
  assign dataOeN = outputEnableN | outputsMasked;
endmodule // sync_burst_sram_control_port

// ### test/sram_port_asserts.sv
`timescale 1ns/1ps
module sram_port_asserts (
  input wire clock, // Clock
  input wire reset, // Reset
  input wire advance_or_load, // Advance
  input wire writeEnableN, // Write
  input wire clock_qualify_n, // Qualify
  input wire chip_select_a_n, // Select
  input wire chip_select_b, // Select
  input wire chip_select_c_n, // Select
  input wire outputEnableN, // Enable
  input wire dataOeN, // Drive
  input wire selected // Active
);
  wire load = !clock_qualify_n && !advance_or_load;
  wire hit = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);
  a_select_taken: assert property (load && hit
    |=> selected) else $error("select missed");
  a_deselect_taken: assert property (load && !hit
    |=> !selected) else $error("deselect missed");
  a_freeze_hold: assert property (clock_qualify_n
    |=> $stable(selected)) else $error("state moved");
  a_idle_quiet: assert property (!selected
    |-> dataOeN) else $error("driving while idle");
  a_enable_off: assert property (outputEnableN
    |-> dataOeN) else $error("driving while disabled");
  a_write_quiet: assert property (load && hit && !writeEnableN
    |=> dataOeN) else $error("driving in write");
  a_emerge_quiet: assert property ($rose(selected)
    |-> dataOeN) else $error("driving on first cycle");
  a_read_drives: assert property (selected && $past(selected)
    && !outputEnableN && $past(load && writeEnableN) |-> !dataOeN)
    else $error("read not driven");
endmodule // sram_port_asserts

// ### test/memory_host_model.sv
`timescale 1ns/1ps
module memory_host_model (
  input wire clock, // Clock
  output reg [20:0] address = 21'h0, // Address
  output reg advance_or_load = 1'b0, // Advance
  output reg writeEnableN = 1'b1, // Write
  output reg byte_lane_strobe_first_n = 1'b1, // Lane 0
  output reg byte_lane_strobe_second_n = 1'b1, // Lane 1
  output reg byte_lane_strobe_third_n = 1'b1, // Lane 2
  output reg byte_lane_strobe_fourth_n = 1'b1, // Lane 3
  output reg clock_qualify_n = 1'b0, // Qualify
  output reg chip_select_a_n = 1'b1, // Select
  output reg chip_select_b = 1'b0, // Select
  output reg chip_select_c_n = 1'b1, // Select
  output reg outputEnableN = 1'b1, // Enable
  output reg [31:0] dataIn = 32'h0, // Data
  output reg [3:0] parity_data_lines_in = 4'h0 // Parity
);
  // One command a cycle, changed at the falling edge
  task cmd(input [20:0] a, input adv, we, input [3:0] bw,
    input [2:0] cs, input cq, oe, input [35:0] d);
    begin
      @(negedge clock);
      address <= a;
      advance_or_load <= adv;
      writeEnableN <= we;
      {byte_lane_strobe_fourth_n, byte_lane_strobe_third_n,
        byte_lane_strobe_second_n, byte_lane_strobe_first_n} <= bw;
      {chip_select_a_n, chip_select_b, chip_select_c_n} <= cs;
      clock_qualify_n <= cq;
      outputEnableN <= oe;
      {parity_data_lines_in, dataIn} <= d;
      @(posedge clock);
      #1;
    end
  endtask
endmodule // memory_host_model

// ### test/sync_burst_sram_control_port_tb.sv
`timescale 1ns/1ps
module sync_burst_sram_control_port_tb;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg burstOrderStrap = 1'b0;
  wire [20:0] address;
  wire [31:0] dataIn, dataOut;
  wire [3:0] parity_data_lines_in, parity_data_lines_out;
  wire advance_or_load, writeEnableN, clock_qualify_n, outputEnableN;
  wire byte_lane_strobe_first_n, byte_lane_strobe_second_n;
  wire byte_lane_strobe_third_n, byte_lane_strobe_fourth_n;
  wire chip_select_a_n, chip_select_b, chip_select_c_n, dataOeN, selected;
  wire [35:0] word = {parity_data_lines_out, dataOut};
  integer fail_count = 0;
  integer tests_run = 0;
  integer i;
  sync_burst_sram_control_port sync_burst_sram_control_port_inst (.*);
  memory_host_model host (.*);
  initial forever #10 clock = ~clock;
  task check(input [63:0] what, input [35:0] exp, got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task t_select;
    for (i = 0; i < 8; i = i + 1) begin
      host.cmd(0, 0, 1, 4'hf, i, 0, 0, 36'h0);
      check("selected", i == 2, selected);
    end
  endtask
  task t_write;
    begin
      host.cmd(4, 0, 0, 4'h0, 2, 0, 0, 36'h0);
      host.cmd(4, 0, 0, 4'ha, 2, 0, 0, 36'h0);
      check("drive", 1, dataOeN);
      host.cmd(4, 0, 1, 4'h0, 2, 0, 0, ~36'h0);
      host.cmd(4, 0, 1, 4'h0, 2, 0, 0, 36'h0);
      check("word", 36'h5_00ff_00ff, word);
      check("drive", 0, dataOeN);
    end
  endtask
  task t_burst;
    begin
      host.cmd(5, 0, 0, 4'h0, 2, 0, 0, 36'h0);
      host.cmd(9, 1, 0, 4'h0, 2, 0, 0, 36'h1_2345_6789);
      host.cmd(5, 0, 1, 4'hf, 2, 0, 0, 36'h9_8765_4321);
      check("beat0", 36'h1_2345_6789, word);
      host.cmd(9, 1, 1, 4'hf, 2, 0, 0, 36'h0);
      check("beat1", 36'h9_8765_4321, word);
    end
  endtask
  task t_desel;
    begin
      host.cmd(0, 0, 1, 4'hf, 0, 0, 0, 36'h0);
      check("drive", 1, dataOeN);
      host.cmd(4, 0, 1, 4'hf, 2, 0, 0, 36'h0);
      check("drive", 1, dataOeN);
      host.cmd(5, 0, 0, 4'h0, 2, 1, 0, 36'h0);
      check("hold", 36'h5_00ff_00ff, word);
      check("selected", 1, selected);
      host.cmd(4, 0, 1, 4'hf, 2, 0, 1, 36'h0);
      check("drive", 1, dataOeN);
    end
  endtask
  task t_order;
    begin
      @(negedge clock);
      burstOrderStrap = 1'b1;
      host.cmd(0, 0, 1, 4'hf, 0, 0, 1, 36'h0);
      host.cmd(0, 0, 1, 4'hf, 0, 0, 1, 36'h0);
      host.cmd(5, 0, 0, 4'h0, 2, 0, 1, 36'h0);
      host.cmd(9, 1, 0, 4'h0, 2, 0, 1, 36'h0_aaaa_5555);
      host.cmd(4, 0, 1, 4'hf, 2, 0, 0, 36'hf_5555_aaaa);
      check("order1", 36'hf_5555_aaaa, word);
      check("drive", 0, dataOeN);
      host.cmd(5, 0, 1, 4'hf, 2, 0, 0, 36'h0);
      check("order0", 36'h0_aaaa_5555, word);
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    t_select;
    t_write;
    t_burst;
    t_desel;
    t_order;
    stop_test;
  end
endmodule // sync_burst_sram_control_port_tb
bind sync_burst_sram_control_port sram_port_asserts sram_port_asserts_inst (.*);
